/* src/reset_combiner_defines.svh */
// What this block does
// - accept all eight reset sources
// - any active source asserts system reset
// - system reset driven out, receivers choose what to keep
// - each source sets its own cause flag
// - power-on clears flags except power-on flag
// - software may write any flag except while power-on is active
// - software flag writes never cause reset
// - extra watchdog and power-saving bits held
`ifndef RESET_COMBINER_DEFINES_SVH
`define RESET_COMBINER_DEFINES_SVH

////////////////////////////////////////////////////////////////////////
// register offsets (byte addresses, one 32-bit word each)
`define CAUSE_REG_OFS     4'h0
`define LIVE_REG_OFS      4'h4

////////////////////////////////////////////////////////////////////////
// cause register bit positions
`define POWER_ON_BIT      0
`define BROWNOUT_BIT      1
`define IDLE_BIT          2
`define SLEEP_BIT         3
`define WATCHDOG_BIT      4
`define WDT_SW_EN_BIT     5
`define RESET_INSTR_BIT   6
`define MASTER_CLEAR_BIT  7
`define CFG_MISMATCH_BIT  8
`define ILLEGAL_COND_BIT  9
`define TRAP_CONFLICT_BIT 15

// writable bits of the cause register
`define CAUSE_WR_MASK     16'h83ff
// value after power-on: only the power-on flag set
`define CAUSE_RESET_VAL   16'h0001

////////////////////////////////////////////////////////////////////////
// timing
`define CLK_PERIOD_NS     20
`define CLEAR_FILTER_NS   200
`define CLEAR_FILTER_CYC  ((`CLEAR_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_MIN_NS        100
`define RST_MIN_CYC       ((`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* src/reset_combiner_pkg.sv */
package reset_combiner_pkg;

    // one avalon request as seen by the slave
    typedef struct packed {
        logic        read;       // read strobe
        logic        write;      // write strobe
        logic [3:0]  address;    // byte address
        logic [3:0]  byteenable; // lane enables
        logic [31:0] writedata;  // write data
    } avalon_req_t;

    // live view of the reset sources, one bit each
    typedef struct packed {
        logic trap_conflict;
        logic illegal_cond;
        logic cfg_mismatch;
        logic master_clear;
        logic reset_instr;
        logic watchdog;
        logic brownout;
        logic power_on;
    } reset_sources_t;

    // bus slave handshake states
    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;

endpackage : reset_combiner_pkg

/* src/master_clear_filter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "reset_combiner_defines.svh"

module master_clear_filter (
    input  wire logic ref_clk_i,        // system clock
    input  wire logic reset_i,          // sync reset, active high
    input  wire logic pin_n_i,          // raw clear pin, low = clear
    output logic      clear_o           // filtered clear, active high
);

    localparam logic [3:0] FILT_CYC = 4'(`CLEAR_FILTER_CYC);

    logic       sync1_reg;      // first synchroniser stage
    logic       sync2_reg;      // second synchroniser stage
    logic       stable_reg;     // accepted clear level
    logic       stable_next;
    logic [3:0] cnt_reg;        // cycles the new level has held
    logic [3:0] cnt_next;

    ////////////////////////////////////////////////////////////////////
    // a level must hold for the whole window before it is accepted,
    // so short spikes on the pin never reach system reset
    always_comb begin
        stable_next = stable_reg;
        cnt_next    = 4'h0;
        if (sync2_reg != stable_reg) begin
            if (cnt_reg == FILT_CYC - 4'h1) begin
                stable_next = sync2_reg;
            end else begin
                cnt_next = cnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sync1_reg  <= 1'b0;
            sync2_reg  <= 1'b0;
            stable_reg <= 1'b0;
            cnt_reg    <= 4'h0;
        end else begin
            sync1_reg  <= ~pin_n_i;
            sync2_reg  <= sync1_reg;
            stable_reg <= stable_next;
            cnt_reg    <= cnt_next;
        end
    end

    assign clear_o = stable_reg;

endmodule : master_clear_filter

`default_nettype wire

/* src/reset_stretch.sv */
`timescale 1ns/1ps
`default_nettype none
`include "reset_combiner_defines.svh"

module reset_stretch (
    input  wire logic ref_clk_i,        // system clock
    input  wire logic reset_i,          // sync reset, active high
    input  wire logic any_i,            // any source active
    output logic      rst_o             // stretched system reset
);

    localparam logic [3:0] MIN_CYC = 4'(`RST_MIN_CYC);

    logic       rst_reg;        // registered reset output
    logic       rst_next;
    logic [3:0] hold_reg;       // cycles left after release
    logic [3:0] hold_next;

    ////////////////////////////////////////////////////////////////////
    // one-cycle sources such as the reset instruction still give a
    // reset long enough for every register to see it
    always_comb begin
        rst_next  = rst_reg;
        hold_next = hold_reg;
        if (any_i) begin
            rst_next  = 1'b1;
            hold_next = MIN_CYC;
        end else if (hold_reg != 4'h0) begin
            hold_next = hold_reg - 4'h1;
        end else begin
            rst_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rst_reg  <= 1'b1;
            hold_reg <= MIN_CYC;
        end else begin
            rst_reg  <= rst_next;
            hold_reg <= hold_next;
        end
    end

    assign rst_o = rst_reg;

endmodule : reset_stretch

`default_nettype wire

/* src/reset_source_combiner.sv */
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "reset_combiner_defines.svh"

module reset_source_combiner (
    input  wire logic        ref_clk_i,           // system clock
    input  wire logic        reset_i,             // power-on, sync
    // reset sources
    input  wire logic        power_on_i,          // rise detect
    input  wire logic        brownout_i,          // brown-out level
    input  wire logic        master_clear_pin_n_i,// clear pin, low
    input  wire logic        reset_instr_i,       // reset opcode
    input  wire logic        watchdog_timeout_i,  // watchdog expiry
    input  wire logic        cfg_mismatch_i,      // config mismatch
    input  wire logic        trap_conflict_i,     // trap conflict
    input  wire logic        illegal_opcode_i,    // bad opcode
    input  wire logic        uninit_wreg_i,       // uninit register
    input  wire logic        security_i,          // security fault
    // power-saving events
    input  wire logic        enter_sleep_i,       // sleep entered
    input  wire logic        enter_idle_i,        // idle entered
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_i,       // byte address
    input  wire logic        avs_read_i,          // read strobe
    input  wire logic        avs_write_i,         // write strobe
    input  wire logic [3:0]  avs_byteenable_i,    // lane enables
    input  wire logic [31:0] avs_writedata_i,     // write data
    output logic [31:0]      avs_readdata_o,      // read data
    output logic             avs_waitrequest_o,   // stall, high
    // results
    output logic             system_reset_out_o,  // combined reset
    output logic             wdt_sw_enable_o      // watchdog enable
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    reset_combiner_pkg::avalon_req_t    req;      // bundled request
    reset_combiner_pkg::reset_sources_t src;      // live sources
    reset_combiner_pkg::bus_state_t     bus_reg;  // handshake state
    reset_combiner_pkg::bus_state_t     bus_next;

    logic        clear_filt;     // filtered clear pin
    logic        illegal_any;    // any illegal condition
    logic        any_src;        // one or more sources active
    logic        sys_rst;        // stretched reset from helper

    logic [15:0] cause_reg;      // reset cause register
    logic [15:0] cause_next;
    logic [15:0] hw_set;         // flags raised by hardware
    logic [15:0] sw_val;         // value after software write
    logic        sw_wr;          // write to cause register

    logic [31:0] rdata_reg;      // registered read data
    logic [31:0] rdata_next;
    logic        rst_out_reg;    // registered system reset
    logic        wdt_en_reg;     // registered watchdog enable
    logic        wait_reg;       // registered waitrequest, high = stall

    ////////////////////////////////////////////////////////////////////
    // helpers

    // merge byte lanes 0 and 1 of a write into the old value
    function automatic logic [15:0] lane_merge(
        input logic [15:0] old_v,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        logic [15:0] v;
        v = old_v;
        if (be[0]) begin
            v[7:0] = wd[7:0];
        end
        if (be[1]) begin
            v[15:8] = wd[15:8];
        end
        return v;
    endfunction : lane_merge

    // one address compare, shared by read and write paths
    function automatic logic hit(
        input logic [3:0] a,
        input logic [3:0] ofs
    );
        return a == ofs;
    endfunction : hit

    ////////////////////////////////////////////////////////////////////
    // request bundle

    assign req.read       = avs_read_i;
    assign req.write      = avs_write_i;
    assign req.address    = avs_address_i;
    assign req.byteenable = avs_byteenable_i;
    assign req.writedata  = avs_writedata_i;

    ////////////////////////////////////////////////////////////////////
    // clear pin filter, the only source from outside the die

    master_clear_filter u_clear_filter (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .pin_n_i   (master_clear_pin_n_i),
        .clear_o   (clear_filt)
    );

    ////////////////////////////////////////////////////////////////////
    // source collection

    // three illegal conditions share one cause flag
    assign illegal_any = illegal_opcode_i
                       | uninit_wreg_i
                       | security_i;

    assign src.power_on      = power_on_i;
    assign src.brownout      = brownout_i;
    assign src.master_clear  = clear_filt;
    assign src.reset_instr   = reset_instr_i;
    assign src.watchdog      = watchdog_timeout_i;
    assign src.cfg_mismatch  = cfg_mismatch_i;
    assign src.trap_conflict = trap_conflict_i;
    assign src.illegal_cond  = illegal_any;

    // only real sources feed the reset; cause bits never do
    assign any_src = |src;

    ////////////////////////////////////////////////////////////////////
    // reset stretcher: held while any source stays active

    reset_stretch u_stretch (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .any_i     (any_src),
        .rst_o     (sys_rst)
    );

    ////////////////////////////////////////////////////////////////////
    // hardware flag sets, one flag per source

    always_comb begin
        hw_set = 16'h0000;
        hw_set[`POWER_ON_BIT]      = src.power_on;
        hw_set[`BROWNOUT_BIT]      = src.brownout;
        hw_set[`MASTER_CLEAR_BIT]  = src.master_clear;
        hw_set[`RESET_INSTR_BIT]   = src.reset_instr;
        hw_set[`WATCHDOG_BIT]      = src.watchdog;
        hw_set[`CFG_MISMATCH_BIT]  = src.cfg_mismatch;
        hw_set[`TRAP_CONFLICT_BIT] = src.trap_conflict;
        hw_set[`ILLEGAL_COND_BIT]  = src.illegal_cond;
        // power-saving status kept beside the causes
        hw_set[`SLEEP_BIT]         = enter_sleep_i;
        hw_set[`IDLE_BIT]          = enter_idle_i;
    end

    ////////////////////////////////////////////////////////////////////
    // cause register next value

    // write commits on the cycle waitrequest is low
    assign sw_wr = (bus_reg == reset_combiner_pkg::BUS_ACK)
                 & req.write
                 & hit(req.address, `CAUSE_REG_OFS);

    assign sw_val = lane_merge(cause_reg, req.writedata,
                               req.byteenable) & `CAUSE_WR_MASK;

    always_comb begin
        cause_next = cause_reg;
        if (src.power_on) begin
            // power-on wipes history, keeps its own flag
            cause_next = `CAUSE_RESET_VAL;
        end else begin
            if (sw_wr) begin
                // any writable bit, either value, any time
                cause_next = sw_val;
            end
            // a source in the same cycle beats the write
            cause_next = cause_next | hw_set;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // avalon slave: waitrequest drops one cycle after a request

    always_comb begin
        bus_next = reset_combiner_pkg::BUS_IDLE;
        case (bus_reg)
            reset_combiner_pkg::BUS_IDLE: begin
                // answer next cycle to any read or write
                if (req.read | req.write) begin
                    bus_next = reset_combiner_pkg::BUS_ACK;
                end
            end
            reset_combiner_pkg::BUS_ACK: begin
                // back to idle so the master can release
                bus_next = reset_combiner_pkg::BUS_IDLE;
            end
            default: begin
                bus_next = reset_combiner_pkg::BUS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // read data, captured together with the acknowledge

    always_comb begin
        rdata_next = 32'h0000_0000;
        if ((bus_reg == reset_combiner_pkg::BUS_IDLE) & req.read) begin
            if (hit(req.address, `CAUSE_REG_OFS)) begin
                // stored status only, live sources elsewhere
                rdata_next = {16'h0000, cause_reg};
            end else if (hit(req.address, `LIVE_REG_OFS)) begin
                // live sources and current reset level
                rdata_next = {23'h000000, sys_rst, src};
            end else begin
                // unmapped addresses read zero
                rdata_next = 32'h0000_0000;
            end
        end else if (bus_reg == reset_combiner_pkg::BUS_ACK) begin
            // keep data standing through the acknowledge edge
            rdata_next = rdata_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state registers
    // reset_i is the power-on clear of this block itself; the rest
    // of the chip is reset through system_reset_out_o, and what it
    // leaves untouched is up to each receiving block

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            cause_reg   <= `CAUSE_RESET_VAL;
            bus_reg     <= reset_combiner_pkg::BUS_IDLE;
            rdata_reg   <= 32'h0000_0000;
            rst_out_reg <= 1'b1;
            wdt_en_reg  <= 1'b0;
            wait_reg    <= 1'b1;
        end else begin
            cause_reg   <= cause_next;
            bus_reg     <= bus_next;
            rdata_reg   <= rdata_next;
            // retiming stage so the output pin sees a clean level
            rst_out_reg <= sys_rst;
            // software watchdog enable lives in the cause register
            wdt_en_reg  <= cause_next[`WDT_SW_EN_BIT];
            // low exactly while the handshake sits in its answer cycle
            wait_reg    <= (bus_next != reset_combiner_pkg::BUS_ACK);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign avs_readdata_o     = rdata_reg;
    assign avs_waitrequest_o  = wait_reg;
    assign system_reset_out_o = rst_out_reg;
    assign wdt_sw_enable_o    = wdt_en_reg;

endmodule : reset_source_combiner

`default_nettype wire

/* sim/reset_source_combiner_props.sv */
`timescale 1ns/1ps
`default_nettype none

module reset_source_combiner_props (
    input wire logic        ref_clk_i,            // system clock
    input wire logic        reset_i,              // sync reset
    input wire logic        power_on_i,           // power-on source
    input wire logic        brownout_i,           // brown-out source
    input wire logic        master_clear_pin_n_i, // clear pin, low
    input wire logic        reset_instr_i,        // reset opcode
    input wire logic        watchdog_timeout_i,   // watchdog expiry
    input wire logic        cfg_mismatch_i,       // config mismatch
    input wire logic        trap_conflict_i,      // trap conflict
    input wire logic        illegal_opcode_i,     // bad opcode
    input wire logic        uninit_wreg_i,        // uninit register
    input wire logic        security_i,           // security fault
    input wire logic        avs_read_i,           // read strobe
    input wire logic        avs_write_i,          // write strobe
    input wire logic [3:0]  avs_address_i,        // byte address
    input wire logic [3:0]  avs_byteenable_i,     // lane enables
    input wire logic [31:0] avs_writedata_i,      // write data
    input wire logic [31:0] avs_readdata_o,       // read data
    input wire logic        avs_waitrequest_o,    // stall
    input wire logic        system_reset_out_o,   // combined reset
    input wire logic        wdt_sw_enable_o       // watchdog enable
);
    logic       any_src;    // any unfiltered source high
    logic [4:0] quiet_reg;  // cycles with every source idle
    logic [4:0] quiet_next; // next quiet count

    assign any_src = power_on_i | brownout_i | reset_instr_i
                   | watchdog_timeout_i | cfg_mismatch_i | trap_conflict_i
                   | illegal_opcode_i | uninit_wreg_i | security_i;

    // saturating count, so long idle spells never wrap back to zero
    always_comb begin
        quiet_next = quiet_reg;
        if (any_src || !master_clear_pin_n_i) begin
            quiet_next = 5'h00;
        end else if (quiet_reg != 5'h1f) begin
            quiet_next = quiet_reg + 5'h01;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        quiet_reg <= reset_i ? 5'h00 : quiet_next;
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    ////////////////////////////////////////////////////////////////////
    a_any_reset: assert property (any_src |-> ##2 system_reset_out_o)
        else $error("source did not raise system reset");
    a_stretch_hold: assert property ($fell(watchdog_timeout_i)
        |-> ##1 system_reset_out_o [*5])
        else $error("system reset dropped too early");
    a_quiet_release: assert property (quiet_reg == 5'h18
        |-> !system_reset_out_o)
        else $error("system reset held with no source");
    a_sw_no_reset: assert property (avs_write_i && !avs_waitrequest_o
        && quiet_reg > 5'h10 |=> !system_reset_out_o [*2])
        else $error("register write raised system reset");
    a_ack_one: assert property ((avs_read_i || avs_write_i)
        && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not one cycle");
    a_idle_wait: assert property (!avs_read_i && !avs_write_i
        |=> avs_waitrequest_o)
        else $error("waitrequest low without request");
    a_wdt_follow: assert property (avs_write_i && !avs_waitrequest_o
        && avs_address_i == 4'h0 && avs_byteenable_i[0] && !power_on_i
        |=> wdt_sw_enable_o == $past(avs_writedata_i[5]))
        else $error("watchdog enable did not follow write");
    a_poweron_wdt: assert property (power_on_i |-> ##2 !wdt_sw_enable_o)
        else $error("power-on left watchdog enable set");
    a_read_zero: assert property (avs_read_i && !avs_waitrequest_o
        |-> avs_readdata_o[31:16] == 16'h0000
        && avs_readdata_o[14:10] == 5'h00)
        else $error("unused read bits not zero");
endmodule : reset_source_combiner_props

bind reset_source_combiner reset_source_combiner_props u_props (.*);

`default_nettype wire

/* sim/reset_source_combiner_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module reset_source_combiner_tb_top;
    logic        ref_clk_i = 1'b0;   // 50 MHz clock
    logic        reset_i   = 1'b1;   // held at start
    logic [11:0] src_reg   = 12'h0;  // source drives, 11 is power-on
    logic        rd_s      = 1'b0;   // bus read strobe
    logic        wr_s      = 1'b0;   // bus write strobe
    logic [3:0]  addr_s    = 4'h0;   // bus address
    logic [3:0]  be_s      = 4'h0;   // bus lanes
    logic [31:0] wdata_s   = 32'h0;  // bus write data
    logic [31:0] rdata;              // read data seen
    logic        waitreq;            // slave stall
    logic        system_reset_out;             // combined reset
    logic        wdt_en;             // watchdog enable
    logic [31:0] exp_q[$];           // expected read data
    logic [15:0] cause_m;            // model of cause flags
    logic [15:0] lfsr      = 16'he85d;
    int          bad_count = 0;
    int          n_tests   = 0;
    // flag each source sets; sleep and idle (8, 9) raise no reset
    localparam logic [15:0] FLAG [12] = '{16'h0002, 16'h0040, 16'h0010,
        16'h0100, 16'h8000, 16'h0200, 16'h0200, 16'h0200, 16'h0008,
        16'h0004, 16'h0080, 16'h0001};

    always #10 ref_clk_i = ~ref_clk_i;

    reset_source_combiner uut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .power_on_i(src_reg[11]), .brownout_i(src_reg[0]),
        .master_clear_pin_n_i(~src_reg[10]), .reset_instr_i(src_reg[1]),
        .watchdog_timeout_i(src_reg[2]), .cfg_mismatch_i(src_reg[3]),
        .trap_conflict_i(src_reg[4]), .illegal_opcode_i(src_reg[5]),
        .uninit_wreg_i(src_reg[6]), .security_i(src_reg[7]),
        .enter_sleep_i(src_reg[8]), .enter_idle_i(src_reg[9]),
        .avs_address_i(addr_s), .avs_read_i(rd_s), .avs_write_i(wr_s),
        .avs_byteenable_i(be_s), .avs_writedata_i(wdata_s),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .system_reset_out_o(system_reset_out), .wdt_sw_enable_o(wdt_en));

    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (bad_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic ran_out;
        bad_count++;
        $display("wrong value at %0t: wait ran out", $time);
        wrap_up();
    endtask : ran_out

    // one bus cycle; held until waitrequest is sampled low
    task automatic bus(input logic rd, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] b,
                       input logic [31:0] want);
        int k;
        if (rd) begin
            exp_q.push_back(want);
        end
        @(posedge ref_clk_i);
        rd_s    <= rd;
        wr_s    <= !rd;
        addr_s  <= a;
        wdata_s <= d;
        be_s    <= b;
        // look at the settled level that the next rising edge samples
        for (k = 0; k < 20; k++) begin
            @(negedge ref_clk_i);
            if (waitreq === 1'b0) break;
        end
        if (k == 20) ran_out();
        @(posedge ref_clk_i);
        rd_s <= 1'b0;
        wr_s <= 1'b0;
    endtask : bus

    // bounded wait for the combined reset to settle at a level
    task automatic wait_rst(input logic v, input int n);
        int k;
        for (k = 0; k < n; k++) begin
            @(posedge ref_clk_i);
            if (system_reset_out === v) break;
        end
        if (k == n) ran_out();
    endtask : wait_rst

    // read data is taken at the falling edge inside the acknowledge cycle only
    always @(negedge ref_clk_i) begin
        if (rd_s && waitreq === 1'b0) check(rdata, exp_q.pop_front());
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        wait_rst(1'b0, 40);
        bus(1'b1, 4'h0, 32'h0, 4'hf, 32'h1);
        // each source alone, flags cleared first, except before power-on, which sets all writable flags; power-on last
        for (int i = 0; i < 12; i++) begin
            bus(1'b0, 4'h0, (i == 11) ? 32'hffff : 32'h0, 4'h3, 32'h0);
            @(posedge ref_clk_i);
            src_reg[i] <= 1'b1;
            repeat ((i == 10) ? 20 : 1) @(posedge ref_clk_i);
            src_reg[i] <= 1'b0;
            repeat (3) @(posedge ref_clk_i);
            check({31'h0, system_reset_out}, {31'h0, (i != 8 && i != 9)});
            wait_rst(1'b0, 40);
            bus(1'b1, 4'h0, 32'h0, 4'hf, {16'h0, FLAG[i]});
        end
        // a short clear-pin glitch must be filtered out
        bus(1'b0, 4'h0, 32'h0, 4'h3, 32'h0);
        src_reg[10] <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        src_reg[10] <= 1'b0;
        repeat (20) @(posedge ref_clk_i);
        check({31'h0, system_reset_out}, 32'h0);
        // unmapped place: reads zero, write lost
        bus(1'b0, 4'h8, 32'hffff, 4'hf, 32'h0);
        bus(1'b1, 4'h8, 32'h0, 4'hf, 32'h0);
        bus(1'b1, 4'h0, 32'h0, 4'hf, 32'h0);
        // random flag writes with random lanes
        cause_m = 16'h0;
        for (int j = 0; j < 8; j++) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            if (lfsr[0]) cause_m[7:0] = lfsr[7:0];
            if (lfsr[1]) cause_m[15:8] = lfsr[15:8];
            cause_m = cause_m & 16'h83ff;
            bus(1'b0, 4'h0, {16'h0, lfsr}, {2'b00, lfsr[1:0]}, 32'h0);
            bus(1'b1, 4'h0, 32'h0, 4'hf, {16'h0, cause_m});
            check({31'h0, wdt_en}, {31'h0, cause_m[5]});
            check({31'h0, system_reset_out}, 32'h0);
        end
        // live view while a source is held
        src_reg[2] <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        bus(1'b1, 4'h4, 32'h0, 4'hf, 32'h0000_0104);
        src_reg[2] <= 1'b0;
        wait_rst(1'b0, 40);
        wrap_up();
    end
endmodule : reset_source_combiner_tb_top

`default_nettype wire
